// *** hw/sram_host_ctrl.sv ***
// Purpose: Host controller driving an asynchronous byte-wide static memory
// Assumes: One request at a time; lowSupply chosen by system; supply steady
// Notes: Every pin output is registered; data lines are split in/out/enable
//
// Operation
// - Host holds write pulse at least 35 ns, or 40 ns low supply.
// - Host write cycle at least 45 ns (55 ns); address 35 ns (50 ns) before end.
// - Host keeps chip selected 35 ns (50 ns) before write end.
// - Host address stable from write start until write end.
// - Host drives write data at least 25 ns before write end.
// - Host may drop write data exactly when write ends.
// - Host never drives data lines while memory drives them.
// - In primary-select retention, host keeps secondary select at a solid rail.
// - Host deselects before retention; waits 5 ms after supply returns.
`timescale 1ns/1ps
`default_nettype none
module sram_host_ctrl #(
   parameter int RECOVERY_COUNT = sram_host_pkg::RECOVERY_CYCLES
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic lowSupply,
   input wire logic retain,
   input wire sram_host_pkg::request_t request,
   input wire logic reqValid,
   output logic reqReady,
   output logic [sram_host_pkg::DATA_W-1:0] readData,
   output logic readValid,
   output logic [sram_host_pkg::ADDR_W-1:0] addressLines,
   output sram_host_pkg::strobes_t strobes,
   input wire logic [sram_host_pkg::DATA_W-1:0] dataLinesIn,
   output logic [sram_host_pkg::DATA_W-1:0] dataLinesOut,
   output logic dataLinesOe
);

   localparam int CW = sram_host_pkg::CNT_W;

   // Refuse a recovery count that the 30-bit wait counter cannot hold
   if (RECOVERY_COUNT < 1 || RECOVERY_COUNT >= (1 << 30)) begin : g_badRecovery
      $error("RECOVERY_COUNT out of range");
   end

   typedef enum logic [2:0] {
      RECOVER, IDLE, READ, WRITE_SETUP, WRITE_PULSE, WRITE_TAIL, TURN, RETAIN
   } state_t;

   state_t state_q;
   logic [CW-1:0] phaseLoad;
   logic phaseStart;
   logic phaseDone;
   logic [29:0] recover_q;
   logic [sram_host_pkg::DATA_W-1:0] sync1_q;
   logic [sram_host_pkg::DATA_W-1:0] sync2_q;
   logic lowSupply_q;

   // ----------------------------------------------------------------
   // Phase timer
   // ----------------------------------------------------------------
   interval_counter #(.WIDTH(CW)) phaseTimer (
      .mclk(mclk),
      .reset(reset),
      .load(phaseStart),
      .loadValue(phaseLoad),
      .done(phaseDone)
   );

   // Latched supply range, taken at idle only
   always_ff @(posedge mclk) begin
      if (reset) begin
         lowSupply_q <= 1'b1;
      end else if (state_q == IDLE) begin
         lowSupply_q <= lowSupply;
      end
   end

   // Phase length chosen from state about to be entered, rounded up
   always_comb begin
      phaseLoad = '0;
      phaseStart = 1'b0;
      unique case (state_q)
         IDLE: begin
            if (reqValid && !retain) begin
               phaseStart = 1'b1;
               if (request.write) begin
                  phaseLoad = CW'(1);
               end else begin
                  phaseLoad = lowSupply_q ? CW'(sram_host_pkg::READ_CYCLES_LO - 1)
                                          : CW'(sram_host_pkg::READ_CYCLES_HI - 1);
               end
            end
         end
         WRITE_SETUP: begin
            phaseStart = phaseDone;
            phaseLoad = lowSupply_q ? CW'(sram_host_pkg::WRITE_PULSE_CYCLES_LO - 1)
                                    : CW'(sram_host_pkg::WRITE_PULSE_CYCLES_HI - 1);
         end
         WRITE_PULSE: begin
            phaseStart = phaseDone;
            phaseLoad = lowSupply_q
               ? CW'(sram_host_pkg::WRITE_CYCLES_LO - sram_host_pkg::WRITE_PULSE_CYCLES_LO - 1)
               : CW'(sram_host_pkg::WRITE_CYCLES_HI - sram_host_pkg::WRITE_PULSE_CYCLES_HI - 1);
         end
         READ: begin
            phaseStart = phaseDone;
            phaseLoad = CW'(sram_host_pkg::RELEASE_CYCLES - 1);
         end
         RECOVER, WRITE_TAIL, TURN, RETAIN: begin
            phaseLoad = '0;
            phaseStart = 1'b0;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (reset) begin
         state_q <= RECOVER;
      end else begin
         unique case (state_q)
            RECOVER: if (recover_q == '0) state_q <= IDLE;
            IDLE: begin
               if (retain) begin
                  state_q <= RETAIN;
               end else if (reqValid) begin
                  state_q <= request.write ? WRITE_SETUP : READ;
               end
            end
            READ: if (phaseDone) state_q <= TURN;
            WRITE_SETUP: if (phaseDone) state_q <= WRITE_PULSE;
            WRITE_PULSE: if (phaseDone) state_q <= WRITE_TAIL;
            WRITE_TAIL: if (phaseDone) state_q <= IDLE;
            TURN: if (phaseDone) state_q <= IDLE;
            RETAIN: if (!retain) state_q <= RECOVER;
         endcase
      end
   end

   // Supply recovery wait after reset or retention
   always_ff @(posedge mclk) begin
      if (reset) begin
         recover_q <= 30'(RECOVERY_COUNT - 1);
      end else if (state_q == RETAIN) begin
         recover_q <= 30'(RECOVERY_COUNT - 1);
      end else if (state_q == RECOVER && recover_q != '0) begin
         recover_q <= recover_q - 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Pin drivers
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (reset) begin
         strobes <= '{primarySelectN: 1'b1, secondarySelect: 1'b0,
                      writeStrobeN: 1'b1, outputGateN: 1'b1};
         addressLines <= '0;
         dataLinesOut <= '0;
         dataLinesOe <= 1'b0;
      end else begin
         unique case (state_q)
            IDLE: begin
               strobes.secondarySelect <= !retain;
               if (reqValid && !retain) begin
                  addressLines <= request.addr;
                  dataLinesOut <= request.wdata;
                  strobes.primarySelectN <= 1'b0;
                  strobes.outputGateN <= request.write;
               end
            end
            WRITE_SETUP: if (phaseDone) begin
               strobes.writeStrobeN <= 1'b0;
               dataLinesOe <= 1'b1;
            end
            WRITE_PULSE: if (phaseDone) begin
               strobes.writeStrobeN <= 1'b1;
               strobes.primarySelectN <= 1'b1;
               dataLinesOe <= 1'b0;
            end
            READ: if (phaseDone) begin
               strobes.outputGateN <= 1'b1;
               strobes.primarySelectN <= 1'b1;
            end
            RETAIN: begin
               strobes.primarySelectN <= 1'b1;
               strobes.secondarySelect <= 1'b0;
            end
            RECOVER, WRITE_TAIL, TURN: begin
               strobes.writeStrobeN <= 1'b1;
            end
         endcase
      end
   end

   // Read data crosses from pins through two flops
   always_ff @(posedge mclk) begin
      if (reset) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= dataLinesIn;
         sync2_q <= sync1_q;
      end
   end

   // Handshake and read capture
   always_ff @(posedge mclk) begin
      if (reset) begin
         reqReady <= 1'b0;
         readValid <= 1'b0;
         readData <= '0;
      end else begin
         reqReady <= (state_q == IDLE) && !(reqValid && !retain) && !retain;
         readValid <= (state_q == TURN) && phaseDone;
         if (state_q == TURN && phaseDone) begin
            readData <= sync2_q;
         end
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_noFight;
      @(posedge mclk) disable iff (reset)
      dataLinesOe |-> (strobes.outputGateN && !strobes.writeStrobeN);
   endproperty
   a_noFight: assert property (p_noFight) else $error("host drives while gate enabled");

   property p_pulseWidth;
      @(posedge mclk) disable iff (reset)
      $fell(strobes.writeStrobeN) |-> !strobes.writeStrobeN [*4];
   endproperty
   a_pulseWidth: assert property (p_pulseWidth) else $error("write pulse too short");

   property p_addrStable;
      @(posedge mclk) disable iff (reset)
      !strobes.primarySelectN |=> $stable(addressLines) || $rose(strobes.primarySelectN);
   endproperty
   a_addrStable: assert property (p_addrStable) else $error("address moved in access");

   property p_dataSetup;
      @(posedge mclk) disable iff (reset)
      $rose(strobes.writeStrobeN) |-> $past(dataLinesOe, 3);
   endproperty
   a_dataSetup: assert property (p_dataSetup) else $error("write data setup short");

   property p_readLen;
      @(posedge mclk) disable iff (reset)
      $fell(strobes.outputGateN) |-> !strobes.outputGateN [*5];
   endproperty
   a_readLen: assert property (p_readLen) else $error("read cycle too short");

   property p_selectBeforeEnd;
      @(posedge mclk) disable iff (reset)
      $rose(strobes.writeStrobeN) |-> $past(!strobes.primarySelectN, 4);
   endproperty
   a_selectBeforeEnd: assert property (p_selectBeforeEnd) else $error("select too late");

   property p_retainDeselect;
      @(posedge mclk) disable iff (reset)
      (state_q == RETAIN) |=> strobes.primarySelectN && !dataLinesOe;
   endproperty
   a_retainDeselect: assert property (p_retainDeselect) else $error("selected in retention");

   property p_dropAtEnd;
      @(posedge mclk) disable iff (reset)
      $rose(strobes.writeStrobeN) |-> !dataLinesOe && strobes.primarySelectN;
   endproperty
   a_dropAtEnd: assert property (p_dropAtEnd) else $error("write end not aligned");

endmodule
`default_nettype wire

// *** common/sram_host_pkg.sv ***
// Purpose: Shared constants and carriers for the asynchronous byte memory host controller
// Assumes: mclk at 100 MHz; memory of 2^20 bytes on an 8-bit shared data bus
// Notes: Timing figures in ns, retention recovery in ms; cycle counts derived from the clock period
package sram_host_pkg;

   // ----------------------------------------------------------------
   // Geometry
   // ----------------------------------------------------------------
   localparam int ADDR_W = 20;
   localparam int DATA_W = 8;

   // ----------------------------------------------------------------
   // Clock
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;

   // ----------------------------------------------------------------
   // Timing figures, high supply range then low supply range
   // ----------------------------------------------------------------
   localparam int READ_CYCLE_MIN_HI_NS = 45;
   localparam int READ_CYCLE_MIN_LO_NS = 55;
   localparam int WRITE_PULSE_MIN_HI_NS = 35;
   localparam int WRITE_PULSE_MIN_LO_NS = 40;
   localparam int ADDRESS_TO_WRITE_END_MIN_HI_NS = 35;
   localparam int ADDRESS_TO_WRITE_END_MIN_LO_NS = 50;
   localparam int WRITE_CYCLE_MIN_HI_NS = 45;
   localparam int WRITE_CYCLE_MIN_LO_NS = 55;
   localparam int DATA_SETUP_MIN_NS = 25;
   localparam int GATE_RELEASE_MAX_HI_NS = 18;
   localparam int GATE_RELEASE_MAX_LO_NS = 20;
   localparam int RETENTION_RECOVERY_MIN_MS = 5;

   // ----------------------------------------------------------------
   // Derived cycle counts, minimums rounded up
   // ----------------------------------------------------------------
   function automatic int ceilCycles(input int ns);
      return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   endfunction

   localparam int READ_CYCLES_HI = ceilCycles(READ_CYCLE_MIN_HI_NS);
   localparam int READ_CYCLES_LO = ceilCycles(READ_CYCLE_MIN_LO_NS);
   // Write pulse covers pulse width, address-to-end, data setup
   localparam int WRITE_PULSE_CYCLES_HI = ceilCycles(ADDRESS_TO_WRITE_END_MIN_HI_NS);
   localparam int WRITE_PULSE_CYCLES_LO = ceilCycles(ADDRESS_TO_WRITE_END_MIN_LO_NS);
   localparam int WRITE_CYCLES_HI = ceilCycles(WRITE_CYCLE_MIN_HI_NS);
   localparam int WRITE_CYCLES_LO = ceilCycles(WRITE_CYCLE_MIN_LO_NS);
   localparam int DATA_SETUP_CYCLES = ceilCycles(DATA_SETUP_MIN_NS);
   // Turnaround wait after gate rises before host drives data
   localparam int RELEASE_CYCLES = ceilCycles(GATE_RELEASE_MAX_LO_NS);
   localparam int RECOVERY_CYCLES = RETENTION_RECOVERY_MIN_MS * 1000000 / CLK_PERIOD_NS;
   localparam int CNT_W = 8;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } request_t;

   typedef struct packed {
      logic primarySelectN;
      logic secondarySelect;
      logic writeStrobeN;
      logic outputGateN;
   } strobes_t;

endpackage

// *** hw/interval_counter.sv ***
// Purpose: Loadable down counter that times one phase of a memory access
// Assumes: Load comes from logic on mclk; count runs down with no enable
// Notes: done is high while the count stands at zero
`timescale 1ns/1ps
`default_nettype none
module interval_counter #(
   parameter int WIDTH = 8
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic load,
   input wire logic [WIDTH-1:0] loadValue,
   output logic done
);

   logic [WIDTH-1:0] count_q;

   // ----------------------------------------------------------------
   // Count down to zero, reload on request
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (reset) begin
         count_q <= '0;
      end else if (load) begin
         count_q <= loadValue;
      end else if (count_q != '0) begin
         count_q <= count_q - 1'b1;
      end
   end

   assign done = (count_q == '0);

endmodule
`default_nettype wire

// *** dv/sram_mem_model.sv ***
// Purpose: Behavioural byte memory standing on the far side of the host controller
// Assumes: Pins as the controller drives them; lowSupply picks the timing range
// Notes: slow answers at the access maximum; violations counts host timing slips
`timescale 1ns/1ps
`default_nettype none
module sram_mem_model (
   input wire logic [sram_host_pkg::ADDR_W-1:0] addressLines,
   input wire sram_host_pkg::strobes_t strobes,
   input wire logic [sram_host_pkg::DATA_W-1:0] dataLinesOut,
   input wire logic dataLinesOe,
   input wire logic lowSupply,
   input wire logic slow,
   output logic [sram_host_pkg::DATA_W-1:0] dataLinesIn,
   output int violations
);
   logic [7:0] mem [int];
   logic [7:0] wrData;
   logic [19:0] wrAddr;
   logic wrOk = 1'b0;
   logic wrOpen = 1'b0;
   int token = 0;
   realtime wrStart = 0, selStart = 0, addrStart = 0, dataStart = 0;
   logic selected, reading, writing;

   // Strobe decode
   assign selected = !strobes.primarySelectN && strobes.secondarySelect;
   assign reading = selected && strobes.writeStrobeN && !strobes.outputGateN;
   assign writing = selected && !strobes.writeStrobeN;
   initial begin
      dataLinesIn = 8'h3c;
      violations = 0;
   end

   // Old byte held, then scrambled lines, then the stored byte after access time
   always @(addressLines or strobes) begin : drive
      automatic int t = token + 1;
      token = t;
      fork
         begin
            #10;
            if (t == token) dataLinesIn = ~dataLinesIn;
            #((slow ? (lowSupply ? 55 : 45) : 12) - 10);
            if (t == token && reading) begin
               dataLinesIn = mem.exists(addressLines) ? mem[addressLines] : ~addressLines[7:0];
            end
         end
      join_none
   end

   // Edge times for the interval checks on the host
   always @(posedge selected) selStart = $realtime;
   always @(addressLines) addrStart = $realtime;
   always @(posedge dataLinesOe) if (reading) violations++;
   always @(posedge writing) begin
      wrStart = $realtime;
      wrAddr = addressLines;
      wrOpen = 1'b1;
   end

   // Latch the byte while the host drives it under an open write
   always @(writing or dataLinesOut or dataLinesOe) begin
      if (writing && dataLinesOe) begin
         if (!wrOk || wrData !== dataLinesOut) dataStart = $realtime;
         wrData = dataLinesOut;
         wrOk = 1'b1;
      end
   end

   // Store at write end and judge the host minimums
   // Unknown strobes settling at reset also look like a falling edge: skip them
   always @(negedge writing) begin
      if (wrOpen) begin
         if ($realtime - wrStart < (lowSupply ? 40 : 35)) violations++;
         if ($realtime - selStart < (lowSupply ? 50 : 35)) violations++;
         if ($realtime - addrStart < (lowSupply ? 50 : 35)) violations++;
         if (addrStart > wrStart) violations++;
         if (!wrOk || $realtime - dataStart < 25) violations++;
         mem[wrAddr] = wrData;
      end
      wrOpen = 1'b0;
      wrOk = 1'b0;
   end
endmodule
`default_nettype wire

// *** dv/testbench.sv ***
// Purpose: Self-checking bench for the byte memory host controller
// Assumes: Recovery shortened to 20 cycles; inputs change at falling edge
// Notes: Memory model judges host timing; bench judges data and strobes
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic mclk = 1'b0, reset = 1'b1, lowSupply = 1'b0, retain = 1'b0, reqValid = 1'b0;
   sram_host_pkg::request_t request = '0;
   logic reqReady, readValid, dataLinesOe;
   logic [7:0] readData, dataLinesIn, dataLinesOut, q;
   logic [19:0] addressLines;
   sram_host_pkg::strobes_t strobes;
   int violations, fails = 0, compares = 0;

   // Clock
   always #5 mclk = ~mclk;

   sram_host_ctrl #(.RECOVERY_COUNT(20)) sram_host_ctrl_inst (.mclk(mclk), .reset(reset),
      .lowSupply(lowSupply), .retain(retain), .request(request), .reqValid(reqValid),
      .reqReady(reqReady), .readData(readData), .readValid(readValid),
      .addressLines(addressLines), .strobes(strobes), .dataLinesIn(dataLinesIn),
      .dataLinesOut(dataLinesOut), .dataLinesOe(dataLinesOe));
   sram_mem_model sram_mem_model_inst (.addressLines(addressLines), .strobes(strobes),
      .dataLinesOut(dataLinesOut), .dataLinesOe(dataLinesOe), .lowSupply(lowSupply),
      .slow(1'b1), .dataLinesIn(dataLinesIn), .violations(violations));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] expv);
      compares++;
      if (got !== expv) begin
         fails++;
         $display("wrong value at %0t got %h expected %h", $time, got, expv);
      end
   endtask

   task automatic conclude;
      $display("counts: compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // Wait at falling edges for reqReady (which 0) or readValid (which 1)
   task automatic waitFor(input int which, input logic level, input int bound);
      int n;
      n = 0;
      @(negedge mclk);
      while (((which == 0) ? reqReady : readValid) !== level) begin
         n++;
         if (n > bound) begin
            fails++;
            $display("wait ran out at %0t", $time);
            conclude();
         end
         @(negedge mclk);
      end
   endtask

   task automatic access(input logic wr, input logic [19:0] a, input logic [7:0] d);
      waitFor(0, 1'b1, 40);
      request = '{write: wr, addr: a, wdata: d};
      reqValid = 1'b1;
      @(negedge mclk);
      reqValid = 1'b0;
      waitFor(0, 1'b0, 4);
      if (!wr) begin
         waitFor(1, 1'b1, lowSupply ? 12 : 10);
         q = readData;
         @(negedge mclk);
         check(readValid, 32'h0000_0000);
      end
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic testReset;
      repeat (20) @(negedge mclk);
      check(strobes, 32'h0000_000b);
      check(dataLinesOe, 32'h0000_0000);
      reset = 1'b0;
      repeat (10) @(negedge mclk);
      check(reqReady, 32'h0000_0000);
      check(strobes.primarySelectN, 32'h0000_0001);
      $display("test reset done");
   endtask

   task automatic testPair(input logic low, input logic [19:0] a0, a1, input logic [7:0] d0);
      lowSupply = low;
      access(1'b1, a0, d0);
      access(1'b1, a1, ~d0);
      access(1'b0, a0, 8'h00);
      check(q, d0);
      access(1'b0, a1, 8'h00);
      check(q, 8'(~d0));
      check(violations, 32'h0000_0000);
      $display("test pair done, low supply %0d", low);
   endtask

   task automatic testRetain;
      waitFor(0, 1'b1, 40);
      retain = 1'b1;
      repeat (3) @(negedge mclk);
      check(strobes.secondarySelect, 32'h0000_0000);
      check(strobes.primarySelectN, 32'h0000_0001);
      request = '{write: 1'b1, addr: 20'h0_0000, wdata: 8'h00};
      reqValid = 1'b1;
      repeat (10) @(negedge mclk);
      check(strobes.writeStrobeN, 32'h0000_0001);
      check(dataLinesOe, 32'h0000_0000);
      reqValid = 1'b0;
      retain = 1'b0;
      access(1'b0, 20'h0_0000, 8'h00);
      check(q, 8'ha5);
      access(1'b0, 20'h1_2345, 8'h00);
      check(q, 8'hba);
      check(violations, 32'h0000_0000);
      $display("test retain done");
   endtask

   // Main sequence
   initial begin
      testReset();
      testPair(1'b0, 20'h0_0000, 20'hf_ffff, 8'ha5);
      testPair(1'b1, 20'h5_5555, 20'ha_aaaa, 8'h3c);
      testRetain();
      conclude();
   end
endmodule
`default_nettype wire
